// File: include/touch_i2c_pkg.sv
// constants, types and helpers shared by both ends of the touch-sensor serial port
// assumes both ends run from one 10 MHz system clock
package touch_i2c_pkg;

    localparam int CLK_NS = 100;

    // fixed upper address bits, direction values
    localparam logic [4:0] ADDR_FIXED = 5'h0F;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;

    // strap connection of the address-select pin and the bits it gives
    typedef enum logic [1:0] {
        STRAP_GND = 2'h0,
        STRAP_SCL = 2'h1,
        STRAP_SDA = 2'h2,
        STRAP_VCC = 2'h3
    } strap_e;

    localparam logic [3:0] BYTE_BITS = 4'h8;

    // master side bus timing
    localparam int T_HALF_NS = 1300;
    localparam int T_HOLD_NS = 300;
    localparam int HALF_CYC = (T_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] HOLD_T = 8'(HOLD_CYC);
    localparam logic [7:0] HALF_T1 = 8'(HALF_CYC - 1);
    localparam logic [7:0] HALF_T2 = 8'(2 * HALF_CYC - 1);
    localparam logic [7:0] HALF_T3 = 8'(3 * HALF_CYC - 1);

    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_RX = 3'h1,
        D_ACK = 3'h3,
        D_TX = 3'h2,
        D_MACK = 3'h6
    } dev_state_e;

    typedef enum logic [1:0] {
        K_ADDR = 2'h0,
        K_REG = 2'h1,
        K_DATA = 2'h3
    } byte_kind_e;

    typedef enum logic [2:0] {
        H_IDLE = 3'h0,
        H_START = 3'h1,
        H_BIT = 3'h3,
        H_STOP = 3'h2,
        H_RESTART = 3'h6
    } host_state_e;

    function automatic logic [6:0] target_addr(input logic [1:0] strap);
        return {ADDR_FIXED, strap};
    endfunction

endpackage

// File: include/touch_i2c_if.sv
// two-wire link between the touch-sensor port and its bus master
// assumes the bench drives addr_sel as the strap wiring (gnd, vcc, scl or sda)
`timescale 1ns/1ps
interface touch_i2c_if;
    logic scl;
    logic sda;
    logic host_sda_o;
    logic host_sda_oe;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic addr_sel;
    logic event_irq_n;
    logic reset_low_pin;

    // open drain with pull-up: any enabled low driver wins
    assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

    modport device (
        input scl,
        input sda,
        input addr_sel,
        input reset_low_pin,
        output dev_sda_o,
        output dev_sda_oe,
        output event_irq_n
    );

    modport host (
        output scl,
        input sda,
        output host_sda_o,
        output host_sda_oe,
        input event_irq_n,
        output reset_low_pin
    );
endinterface

// File: verilog/touch_i2c_device.sv
// target end of the touch-sensor serial port: address match, acks,
// register select, write and read data, event interrupt
// assumes scl, sda, addr_sel and reset_low_pin arrive asynchronously
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// - answer only address 01111 plus strap bits
// - last address bit selects write or read
// - strap gnd 00, vcc 11, scl 01, sda 10
// - sample data while clock high
// - master keeps data high when idle
// - start: data falls, clock high; compare address
// - master sends address byte msb first
// - matching address: hold data low on ninth pulse
// - master stops after missing address ack
// - take register byte, acknowledge it
// - take write data byte, acknowledge it
// - stop: data rises, clock high; end transfer
// - read: write address, register, restart, read
// - read returns the selected register contents
// - interrupt low on touch or release event
module touch_i2c_device
    import touch_i2c_pkg::*;
(
    input logic clk,
    input logic sys_rst,
    touch_i2c_if.device bus,
    output logic [7:0] reg_sel,
    output logic [7:0] wr_data,
    output logic wr_strobe,
    input logic [7:0] rd_data,
    output logic rd_strobe,
    input logic touch_event,
    input logic release_event,
    input logic irq_on_touch,
    input logic irq_on_release,
    input logic irq_clear
);

    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic [1:0] ad_sy;
        logic [1:0] reset_low_pin_sy;
        logic scl_d;
        logic sda_d;
        logic ad_low;
        logic ad_high;
        logic ad_ne_scl;
        dev_state_e st;
        byte_kind_e kind;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic rw;
        logic drv;
        logic nack;
        logic [7:0] reg_sel;
        logic [7:0] wr_data;
        logic wr_strobe;
        logic rd_strobe;
        logic irq;
    } dev_s;

    dev_s r_reg;
    dev_s r_next;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [1:0] strap;
    logic ev_set;

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_next = r_reg;
        // pins pass two flops before any logic looks at them
        r_next.scl_sy = {r_reg.scl_sy[0], bus.scl};
        r_next.sda_sy = {r_reg.sda_sy[0], bus.sda};
        r_next.ad_sy = {r_reg.ad_sy[0], bus.addr_sel};
        r_next.reset_low_pin_sy = {r_reg.reset_low_pin_sy[0], bus.reset_low_pin};
        scl = r_reg.scl_sy[1];
        sda = r_reg.sda_sy[1];
        r_next.scl_d = scl;
        r_next.sda_d = sda;
        r_next.wr_strobe = 1'b0;
        r_next.rd_strobe = 1'b0;

        rise = scl && !r_reg.scl_d;
        fall = !scl && r_reg.scl_d;
        start = scl && r_reg.scl_d && r_reg.sda_d && !sda;
        stop = scl && r_reg.scl_d && !r_reg.sda_d && sda;

        // strap seen since reset: still high, still low, follows scl, else sda
        // sync flops hold reset zeros for two edges: a false low would spoil vcc
        if (r_reg.reset_low_pin_sy[1] && !r_reg.ad_sy[1]) begin
            r_next.ad_low = 1'b1;
        end else if (r_reg.reset_low_pin_sy[1]) begin
            r_next.ad_high = 1'b1;
        end
        if (r_reg.reset_low_pin_sy[1] && r_reg.ad_sy[1] != scl) begin
            r_next.ad_ne_scl = 1'b1;
        end
        if (!r_reg.ad_low) begin
            strap = STRAP_VCC;
        end else if (!r_reg.ad_high) begin
            strap = STRAP_GND;
        end else if (!r_reg.ad_ne_scl) begin
            strap = STRAP_SCL;
        end else begin
            strap = STRAP_SDA;
        end

        // event flag: a set in the clearing cycle wins
        ev_set = (touch_event && irq_on_touch) || (release_event && irq_on_release);
        if (irq_clear) begin
            r_next.irq = 1'b0;
        end
        if (ev_set) begin
            r_next.irq = 1'b1;
        end

        if (stop) begin
            r_next.st = D_IDLE;
            r_next.drv = 1'b0;
        end else if (start) begin
            // also a repeated start from any state
            r_next.st = D_RX;
            r_next.kind = K_ADDR;
            r_next.cnt = 4'h0;
            r_next.drv = 1'b0;
        end else begin
            unique case (r_reg.st)
                D_IDLE: begin
                end
                D_RX: begin
                    if (rise) begin
                        r_next.sh = {r_reg.sh[6:0], sda};
                        r_next.cnt = r_reg.cnt + 4'h1;
                    end else if (fall && r_reg.cnt == BYTE_BITS) begin
                        unique case (r_reg.kind)
                            K_ADDR: begin
                                if (r_reg.sh[7:1] == target_addr(strap)) begin
                                    r_next.rw = r_reg.sh[0];
                                    r_next.drv = 1'b1;
                                    r_next.st = D_ACK;
                                end else begin
                                    r_next.st = D_IDLE;
                                end
                            end
                            K_REG: begin
                                r_next.reg_sel = r_reg.sh;
                                r_next.drv = 1'b1;
                                r_next.st = D_ACK;
                            end
                            K_DATA: begin
                                r_next.wr_data = r_reg.sh;
                                r_next.wr_strobe = 1'b1;
                                r_next.drv = 1'b1;
                                r_next.st = D_ACK;
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    // ack held through the ninth pulse; on its fall dropped, or after a read address replaced by data bit 7
                    if (fall) begin
                        r_next.cnt = 4'h0;
                        if (r_reg.kind == K_ADDR && r_reg.rw == DIR_READ) begin
                            r_next.sh = rd_data;
                            r_next.rd_strobe = 1'b1;
                            r_next.drv = !rd_data[7];
                            r_next.st = D_TX;
                        end else begin
                            r_next.drv = 1'b0;
                            r_next.kind = (r_reg.kind == K_ADDR) ? K_REG : K_DATA;
                            r_next.st = D_RX;
                        end
                    end
                end
                D_TX: begin
                    if (rise) begin
                        r_next.cnt = r_reg.cnt + 4'h1;
                    end else if (fall) begin
                        if (r_reg.cnt == BYTE_BITS) begin
                            r_next.drv = 1'b0;
                            r_next.st = D_MACK;
                        end else begin
                            r_next.sh = {r_reg.sh[6:0], 1'b0};
                            r_next.drv = !r_reg.sh[6];
                        end
                    end
                end
                D_MACK: begin
                    if (rise) begin
                        r_next.nack = sda;
                    end else if (fall) begin
                        r_next.cnt = 4'h0;
                        if (r_reg.nack) begin
                            // master done: wait idle for its stop
                            r_next.st = D_IDLE;
                        end else begin
                            r_next.sh = rd_data;
                            r_next.rd_strobe = 1'b1;
                            r_next.drv = !rd_data[7];
                            r_next.st = D_TX;
                        end
                    end
                end
            endcase
        end

        // reset pin clears the transfer and the event flag, keeps the strap view
        if (!r_reg.reset_low_pin_sy[1]) begin
            r_next.st = D_IDLE;
            r_next.drv = 1'b0;
            r_next.irq = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    assign bus.dev_sda_o = 1'b0;
    assign bus.dev_sda_oe = r_reg.drv;
    assign bus.event_irq_n = !r_reg.irq;
    assign reg_sel = r_reg.reg_sel;
    assign wr_data = r_reg.wr_data;
    assign wr_strobe = r_reg.wr_strobe;
    assign rd_strobe = r_reg.rd_strobe;

endmodule

// File: verilog/touch_i2c_host.sv
// master end: one register write or one register read per command
// assumes the link pins arrive asynchronously; scl is made here by a divider
`timescale 1ns/1ps
module touch_i2c_host
    import touch_i2c_pkg::*;
(
    input logic clk,
    input logic sys_rst,
    touch_i2c_if.host bus,
    input logic cmd_valid,
    output logic cmd_ready,
    input logic cmd_read,
    input logic [1:0] cmd_strap,
    input logic [7:0] cmd_reg,
    input logic [7:0] cmd_wdata,
    input logic hold_reset,
    output logic done,
    output logic nack,
    output logic [7:0] rdata,
    output logic irq_pending
);

    typedef struct packed {
        logic [1:0] sda_sy;
        logic [1:0] irq_sy;
        host_state_e st;
        logic [7:0] tmr;
        logic ph;
        logic [3:0] bitn;
        logic [1:0] idx;
        logic [8:0] sh;
        logic [7:0] rx;
        logic scl;
        logic sda_oe;
        logic rd;
        logic [1:0] strap;
        logic [7:0] regn;
        logic [7:0] wdata;
        logic done;
        logic nack;
        logic [7:0] rdata;
        logic rst_hold;
    } host_s;

    host_s r_reg;
    host_s r_next;
    logic sda;

    // bytes: addr+write, register, then data or addr+read, then read slot
    function automatic logic [8:0] byte_slot(input host_s s, input logic [1:0] i);
        logic [7:0] b;
        b = 8'hFF;
        unique case (i)
            2'h0: b = {target_addr(s.strap), DIR_WRITE};
            2'h1: b = s.regn;
            2'h2: b = s.rd ? {target_addr(s.strap), DIR_READ} : s.wdata;
            2'h3: b = 8'hFF;
        endcase
        // ninth bit released: ack slot, or nack after the read byte
        return {b, 1'b1};
    endfunction

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        r_next = r_reg;
        r_next.sda_sy = {r_reg.sda_sy[0], bus.sda};
        r_next.irq_sy = {r_reg.irq_sy[0], bus.event_irq_n};
        r_next.rst_hold = hold_reset;
        r_next.done = 1'b0;
        sda = r_reg.sda_sy[1];
        r_next.tmr = r_reg.tmr + 8'h01;

        unique case (r_reg.st)
            H_IDLE: begin
                r_next.scl = 1'b1;
                r_next.sda_oe = 1'b0;
                r_next.tmr = 8'h00;
                if (cmd_valid) begin
                    r_next.rd = cmd_read;
                    r_next.strap = cmd_strap;
                    r_next.regn = cmd_reg;
                    r_next.wdata = cmd_wdata;
                    r_next.nack = 1'b0;
                    r_next.sda_oe = 1'b1;
                    r_next.st = H_START;
                end
            end
            H_START: begin
                if (r_reg.tmr == HALF_T1) begin
                    r_next.scl = 1'b0;
                    r_next.tmr = 8'h00;
                    r_next.ph = 1'b0;
                    r_next.bitn = 4'h0;
                    r_next.idx = 2'h0;
                    r_next.sh = byte_slot(r_reg, 2'h0);
                    r_next.st = H_BIT;
                end
            end
            H_BIT: begin
                if (!r_reg.ph) begin
                    if (r_reg.tmr == HOLD_T) begin
                        r_next.sda_oe = !r_reg.sh[8];
                    end
                    if (r_reg.tmr == HALF_T1) begin
                        r_next.scl = 1'b1;
                        r_next.ph = 1'b1;
                        r_next.tmr = 8'h00;
                    end
                end else if (r_reg.tmr == HALF_T1) begin
                    r_next.scl = 1'b0;
                    r_next.ph = 1'b0;
                    r_next.tmr = 8'h00;
                    r_next.sh = {r_reg.sh[7:0], 1'b1};
                    r_next.bitn = r_reg.bitn + 4'h1;
                    if (r_reg.bitn != BYTE_BITS) begin
                        r_next.rx = {r_reg.rx[6:0], sda};
                    end else begin
                        r_next.bitn = 4'h0;
                        if (sda && r_reg.idx != 2'h3) begin
                            r_next.nack = 1'b1;
                            r_next.st = H_STOP;
                        end else if (r_reg.idx == 2'h3) begin
                            r_next.rdata = r_reg.rx;
                            r_next.st = H_STOP;
                        end else if (r_reg.idx == 2'h1 && r_reg.rd) begin
                            r_next.st = H_RESTART;
                        end else if (r_reg.idx == 2'h2 && !r_reg.rd) begin
                            r_next.st = H_STOP;
                        end else begin
                            r_next.idx = r_reg.idx + 2'h1;
                            r_next.sh = byte_slot(r_reg, r_reg.idx + 2'h1);
                        end
                    end
                end
            end
            H_STOP: begin
                if (r_reg.tmr == HOLD_T) begin
                    r_next.sda_oe = 1'b1;
                end
                if (r_reg.tmr == HALF_T1) begin
                    r_next.scl = 1'b1;
                end
                if (r_reg.tmr == HALF_T2) begin
                    r_next.sda_oe = 1'b0;
                end
                if (r_reg.tmr == HALF_T3) begin
                    r_next.done = 1'b1;
                    r_next.st = H_IDLE;
                end
            end
            H_RESTART: begin
                if (r_reg.tmr == HOLD_T) begin
                    r_next.sda_oe = 1'b0;
                end
                if (r_reg.tmr == HALF_T1) begin
                    r_next.scl = 1'b1;
                end
                if (r_reg.tmr == HALF_T2) begin
                    r_next.sda_oe = 1'b1;
                end
                if (r_reg.tmr == HALF_T3) begin
                    r_next.scl = 1'b0;
                    r_next.tmr = 8'h00;
                    r_next.ph = 1'b0;
                    r_next.idx = 2'h2;
                    r_next.sh = byte_slot(r_reg, 2'h2);
                    r_next.st = H_BIT;
                end
            end
            default: begin
                r_next.st = H_IDLE;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            r_reg <= '0;
            r_reg.scl <= 1'b1;
            // irq line idles high: no false pending right after reset
            r_reg.irq_sy <= 2'h3;
        end else begin
            r_reg <= r_next;
        end
    end

    assign bus.scl = r_reg.scl;
    assign bus.host_sda_o = 1'b0;
    assign bus.host_sda_oe = r_reg.sda_oe;
    assign bus.reset_low_pin = !r_reg.rst_hold;
    assign cmd_ready = (r_reg.st == H_IDLE);
    assign done = r_reg.done;
    assign nack = r_reg.nack;
    assign rdata = r_reg.rdata;
    assign irq_pending = !r_reg.irq_sy[1];

endmodule

// File: tb/touch_i2c_link_properties.sv
// concurrent checks on the two-wire link between the two port ends
// assumes one clock domain; sda is the resolved open-drain wire
`timescale 1ns/1ps
module touch_i2c_link_properties (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl,
    input wire logic sda,
    input wire logic host_sda_oe,
    input wire logic dev_sda_oe,
    input wire logic event_irq_n,
    input wire logic reset_low_pin
);
    //////////////////////////////////////////////////////////////////////////////
    logic scl_q;
    logic sda_q;
    logic in_frame;
    logic [4:0] fall_cnt;
    logic [8:0] oe_cnt;
    wire start_now = scl && scl_q && sda_q && !sda;
    wire stop_now = scl && scl_q && !sda_q && sda;
    // clock pulse that carries the address acknowledge
    wire ack_rise = in_frame && fall_cnt == 5'h09 && !scl_q && scl;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_q <= 1'h1;
            sda_q <= 1'h1;
            in_frame <= 1'h0;
            fall_cnt <= 5'h00;
            oe_cnt <= 9'h000;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_now)
                in_frame <= 1'h1;
            else if (stop_now)
                in_frame <= 1'h0;
            // saturates at 5'h1F, so a long frame never wraps back into the address window
            if (start_now)
                fall_cnt <= 5'h00;
            else if (scl_q && !scl && fall_cnt != 5'h1F)
                fall_cnt <= fall_cnt + 5'h01;
            oe_cnt <= dev_sda_oe ? oe_cnt + 9'(oe_cnt != 9'h1FF) : 9'h000;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    oe_on_low_a: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("device data changed while clock high");
    ack_held_a: assert property ($rose(scl) && dev_sda_oe |-> dev_sda_oe [*8])
        else $error("device data not held through clock high");
    idle_release_a: assert property (!in_frame |-> !dev_sda_oe)
        else $error("device drives data outside a frame");
    addr_quiet_a: assert property (in_frame && fall_cnt < 5'h09 |-> !dev_sda_oe)
        else $error("device drives during address bits");
    ack_slot_a: assert property ($rose(dev_sda_oe) && in_frame && fall_cnt <= 5'h09 |-> fall_cnt == 5'h09)
        else $error("address acknowledge outside ninth pulse");
    // nine bits of zero is the longest legal drive
    drive_bounded_a: assert property (oe_cnt < 9'h0F0)
        else $error("device holds data low too long");
    idle_high_a: assert property (!in_frame && !start_now |-> sda)
        else $error("data low with no transfer");
    nack_stop_a: assert property (ack_rise && sda |-> ##[1:80] stop_now)
        else $error("no stop after missing acknowledge");
    pin_clear_a: assert property (!reset_low_pin [*5] |-> event_irq_n)
        else $error("interrupt stays low under reset pin");

    cover property (ack_rise && !sda);
    cover property (ack_rise && sda);
    cover property (start_now && in_frame);
    cover property ($fell(event_irq_n));
endmodule

// File: tb/touch_sensor_i2c_slave_port_tb_top.sv
// bench joining master and target ends over the link interface
// assumes the host makes scl by its own divider; strap wired by the bench
`timescale 1ns/1ps
module touch_sensor_i2c_slave_port_tb_top;
    import touch_i2c_pkg::*;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    strap_e strap_mode = STRAP_GND;
    logic cmd_valid = 1'h0;
    logic cmd_read = 1'h0;
    logic [1:0] cmd_strap = 2'h0;
    logic [7:0] cmd_reg = 8'h00;
    logic [7:0] cmd_wdata = 8'h00;
    logic hold_reset = 1'h0;
    logic [7:0] rd_data = 8'h00;
    logic touch_event = 1'h0;
    logic release_event = 1'h0;
    logic irq_on_touch = 1'h0;
    logic irq_on_release = 1'h0;
    logic irq_clear = 1'h0;
    logic [7:0] reg_sel, wr_data, rdata, last_reg, last_wd;
    logic wr_strobe, rd_strobe, cmd_ready, done, nack, irq_pending;
    int errors = 0;
    int n_compared = 0;
    int n_wr = 0;
    int n_rd = 0;

    always #(CLK_NS / 2) clk = ~clk;

    //////////////////////////////////////////////////////////////////////////////
    touch_i2c_if bus ();
    assign bus.addr_sel = (strap_mode == STRAP_GND) ? 1'h0 : (strap_mode == STRAP_VCC) ? 1'h1 :
                          (strap_mode == STRAP_SCL) ? bus.scl : bus.sda;

    touch_i2c_device u_touch_i2c_device (.clk(clk), .sys_rst(sys_rst), .bus(bus.device), .reg_sel(reg_sel),
        .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_data(rd_data), .rd_strobe(rd_strobe),
        .touch_event(touch_event), .release_event(release_event), .irq_on_touch(irq_on_touch),
        .irq_on_release(irq_on_release), .irq_clear(irq_clear));
    touch_i2c_host u_touch_i2c_host (.clk(clk), .sys_rst(sys_rst), .bus(bus.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_strap(cmd_strap), .cmd_reg(cmd_reg),
        .cmd_wdata(cmd_wdata), .hold_reset(hold_reset), .done(done), .nack(nack), .rdata(rdata),
        .irq_pending(irq_pending));
    touch_i2c_link_properties u_touch_i2c_link_properties (.clk(clk), .sys_rst(sys_rst), .scl(bus.scl),
        .sda(bus.sda), .host_sda_oe(bus.host_sda_oe), .dev_sda_oe(bus.dev_sda_oe),
        .event_irq_n(bus.event_irq_n), .reset_low_pin(bus.reset_low_pin));

    // strobes are single cycles, so count them as they pass
    always @(posedge clk) begin
        if (wr_strobe === 1'h1) begin
            n_wr <= n_wr + 1;
            last_reg <= reg_sel;
            last_wd <= wr_data;
        end
        if (rd_strobe === 1'h1)
            n_rd <= n_rd + 1;
    end

    //////////////////////////////////////////////////////////////////////////////
    function automatic logic exp_nack(input logic [1:0] dev_strap, input logic [1:0] sent);
        return {ADDR_FIXED, sent} != target_addr_bits(dev_strap);
    endfunction

    function automatic logic [6:0] target_addr_bits(input logic [1:0] s);
        return {5'h0F, s};
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic do_reset(input strap_e s);
        @(posedge clk);
        strap_mode <= s;
        sys_rst <= 1'h1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic run_cmd(input logic rd, input logic [1:0] s, input logic [7:0] r, input logic [7:0] w);
        int i;
        @(negedge clk);
        for (i = 0; i < 50 && cmd_ready !== 1'h1; i++)
            @(negedge clk);
        @(posedge clk);
        cmd_valid <= 1'h1;
        cmd_read <= rd;
        cmd_strap <= s;
        cmd_reg <= r;
        cmd_wdata <= w;
        @(posedge clk);
        cmd_valid <= 1'h0;
        for (i = 0; i < 4000; i++) begin
            @(negedge clk);
            if (done === 1'h1)
                break;
        end
        if (i == 4000)
            check(8'h00, 8'h01);
    endtask

    task automatic irq_step(input logic t, input logic r, input logic c, input logic exp_n);
        @(posedge clk);
        touch_event <= t;
        release_event <= r;
        irq_clear <= c;
        @(posedge clk);
        touch_event <= 1'h0;
        release_event <= 1'h0;
        irq_clear <= 1'h0;
        repeat (5) @(negedge clk);
        check({7'h00, bus.event_irq_n}, {7'h00, exp_n});
        check({7'h00, irq_pending}, {7'h00, !exp_n});
    endtask

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (80000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        logic [7:0] r;
        logic [7:0] w;
        logic [7:0] d;
        int n0;
        int k;
        int s;
        void'($urandom(32'h5847C36C));
        for (s = 0; s < 4; s++) begin
            do_reset(strap_e'(s));
            for (k = 0; k < 4; k++) begin
                r = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom);
                w = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
                d = 8'($urandom);
                n0 = n_wr;
                run_cmd(1'h0, 2'(s), r, w);
                check({7'h00, nack}, 8'h00);
                check(8'(n_wr - n0), 8'h01);
                check(last_reg, r);
                check(last_wd, w);
                @(posedge clk);
                rd_data <= d;
                n0 = n_rd;
                run_cmd(1'h1, 2'(s), w, 8'h00);
                check({7'h00, nack}, 8'h00);
                check(reg_sel, w);
                check(rdata, d);
                check(8'(n_rd != n0), 8'h01);
            end
            for (k = 1; k < 4; k++) begin
                n0 = n_wr;
                run_cmd(1'h0, 2'(s) ^ 2'(k), 8'($urandom), 8'($urandom));
                check({7'h00, nack}, {7'h00, exp_nack(2'(s), 2'(s) ^ 2'(k))});
                check(8'(n_wr - n0), 8'h00);
            end
        end
        @(posedge clk);
        irq_on_touch <= 1'h1;
        irq_step(1'h1, 1'h0, 1'h0, 1'h0);
        irq_step(1'h0, 1'h0, 1'h1, 1'h1);
        irq_step(1'h0, 1'h1, 1'h0, 1'h1);
        @(posedge clk);
        irq_on_release <= 1'h1;
        irq_step(1'h0, 1'h1, 1'h0, 1'h0);
        // event and clear in one cycle: the set wins
        irq_step(1'h1, 1'h0, 1'h1, 1'h0);
        // reset pin is a protocol reset that also drops the flag
        @(posedge clk);
        hold_reset <= 1'h1;
        repeat (10) @(posedge clk);
        hold_reset <= 1'h0;
        repeat (5) @(negedge clk);
        check({7'h00, bus.event_irq_n}, 8'h01);
        results();
    end
endmodule
